//--- usart_pkg.sv
package usart_pkg;

    localparam int ADDR_W = 8;

    // register byte offsets
    localparam logic [7:0] OFS_CSA = 8'h00;
    localparam logic [7:0] OFS_CSB = 8'h04;
    localparam logic [7:0] OFS_CSC = 8'h08;
    localparam logic [7:0] OFS_BAUD_LO = 8'h0c;
    localparam logic [7:0] OFS_BAUD_HI = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;

    // ctrl_status_a fields
    localparam int CSA_RXC = 7;
    localparam int CSA_TXC = 6;
    localparam int CSA_TBE = 5;
    localparam int CSA_FE = 4;
    localparam int CSA_U2 = 1;
    // ctrl_status_b fields
    localparam int CSB_RXEN = 4;
    localparam int CSB_TXEN = 3;
    localparam int CSB_CS2 = 2;
    localparam int CSB_RX8 = 1;
    localparam int CSB_TX8 = 0;
    // ctrl_status_c fields
    localparam int CSC_MASTER = 7;
    localparam int CSC_SYNC = 6;
    localparam int CSC_PM = 4;
    localparam int CSC_SBS = 3;
    localparam int CSC_CS = 1;
    localparam int CSC_POL = 0;

    localparam logic [7:0] CSB_RESET = 8'h00;
    localparam logic [7:0] CSC_RESET = 8'h06;
    localparam logic [11:0] DIVISOR_RESET = 12'h000;

    // last sample index within one bit: 16 or 8 ticks per bit
    localparam logic [3:0] OS_NORMAL_LAST = 4'hf;
    localparam logic [3:0] OS_DOUBLE_LAST = 4'h7;
    localparam int SYNC_DELAY = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_PARITY = 5'h08,
        TX_STOP = 5'h10
    } tx_state_t;

    typedef enum logic [4:0] {
        RX_IDLE = 5'h01,
        RX_START = 5'h02,
        RX_DATA = 5'h04,
        RX_PARITY = 5'h08,
        RX_STOP = 5'h10
    } rx_state_t;

    function automatic logic [3:0] data_bits(input logic [2:0] cs);
        case (cs)
            3'h0: return 4'h5;
            3'h1: return 4'h6;
            3'h2: return 4'h7;
            3'h7: return 4'h9;
            default: return 4'h8;
        endcase
    endfunction

    function automatic logic parity_of(input logic [8:0] d, input logic [3:0] n,
                                       input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) p = p ^ d[i];
        end
        return p;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= OFS_DATA);
    endfunction

endpackage

//--- usart_xck_edge.sv
`timescale 1ns/1ns
module usart_xck_edge (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // external transfer clock
    input wire logic xck_in,
    // detected edges
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic [2:0] sr;
    } edge_state_t;

    edge_state_t s;
    edge_state_t next_s;

    // sr[0] is the synchroniser stage, only sr[1] reads it
    always_comb begin
        next_s = s;
        next_s.sr = {s.sr[1:0], xck_in};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rise = s.sr[1] & ~s.sr[2];
    assign fall = ~s.sr[1] & s.sr[2];
endmodule

//--- usart_core.sv
`timescale 1ns/1ns
// Operation
// RULE1: double speed in async mode divides baud ticks by 8, not 16.
// RULE2: double speed is ignored in sync mode; software keeps it zero.
// RULE3: double-speed receiver takes 8 samples per bit instead of 16.
// RULE4: slave clock passes a sync register and edge detector, two clocks late.
// RULE5: external slave clock stays below a quarter of the system clock.
// RULE6: in sync mode transfer clock pin is output as master, input as slave.
// RULE7: sync receive samples on the edge opposite to transmit change.
// RULE8: polarity zero changes data on rising, samples falling; one swaps.
// RULE9: thirty formats: start, 5-9 data, none/even/odd parity, 1-2 stops.
// RULE10: frame order start, data lsb first, optional parity, stops.
// RULE11: after a frame the next starts at once or the line idles high.
// RULE12: start bit always low, each stop bit always high.
// RULE13: both directions share one format; change it only when idle.
// RULE14: 3-bit size field, 2-bit parity field, one stop-count bit.
// RULE15: receiver ignores second stop; frame error only on low first stop.
// RULE16: parity is xor of data bits, inverted for odd.
// RULE17: while transmit enabled the device drives the serial output pin.
// RULE18: data write fills buffer, moved to shifter when idle or after stop.
// RULE19: unused upper data bits are ignored for short characters.
// RULE20: software changes baud or format only with no transfer running.
// RULE21: software clears transmit-complete before each data write if used.
// RULE22: polling software waits for buffer-empty before writing data.
// RULE23: baud down-counter reloads at zero or low write, one tick per zero.
// RULE24: baud divisor is 12 bits from high and low registers, 0 to 4095.
// RULE25: buffer-empty flag set while buffer has no waiting data.
// RULE26: transmit-complete set when frame ends with empty buffer; write one clears.
// RULE27: enabled transmitter with no frame holds the line idle high.
module usart_core
    import usart_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // serial line
    output logic txd_out,
    output logic txd_oe,
    input wire logic rxd_in,
    // transfer clock pin
    input wire logic xck_in,
    output logic xck_out,
    output logic xck_oe
);
    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic double_speed;
        logic [7:0] csb;
        logic [7:0] csc;
        logic [11:0] divisor;
        logic [11:0] baud_cnt;
        logic xck_int;
        logic [8:0] tx_buf;
        logic tx_full;
        logic tx_complete;
        tx_state_t tx_state;
        logic [3:0] tx_pre;
        logic [8:0] tx_shift;
        logic [3:0] tx_cnt;
        logic tx_par;
        logic txd;
        rx_state_t rx_state;
        logic [3:0] rx_pre;
        logic [8:0] rx_shift;
        logic [3:0] rx_cnt;
        logic [8:0] rx_data;
        logic rx_complete;
        logic frame_error;
    } core_state_t;

    core_state_t s;
    core_state_t next_s;

    logic sl_rise;
    logic sl_fall;

    usart_xck_edge u_xck_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .xck_in(xck_in),
        .rise(sl_rise),
        .fall(sl_fall)
    );

    logic sync_mode, master, dbl, baud_tick, xe_rise, xe_fall, chg_edge, smp_edge;
    logic tx_bit, rx_smp, par_en, par_odd, tx_en, do_wr, wr_ok, lo_wr, data_wr;
    logic tx_load, tx_last, ar_take;
    logic [3:0] os_last, os_mid, nbits;
    logic [7:0] rd_mux;

    always_comb begin
        sync_mode = s.csc[CSC_SYNC];
        master = s.csc[CSC_MASTER];
        dbl = s.double_speed & ~sync_mode; // RULE2
        os_last = dbl ? OS_DOUBLE_LAST : OS_NORMAL_LAST; // RULE1 RULE3
        os_mid = {1'b0, os_last[3:1]};
        baud_tick = (s.baud_cnt == 12'h000); // RULE23
        xe_rise = master ? (baud_tick & ~s.xck_int) : sl_rise; // RULE4
        xe_fall = master ? (baud_tick & s.xck_int) : sl_fall;
        chg_edge = s.csc[CSC_POL] ? xe_fall : xe_rise; // RULE8
        smp_edge = s.csc[CSC_POL] ? xe_rise : xe_fall; // RULE7
        tx_bit = sync_mode ? chg_edge : (baud_tick && s.tx_pre == os_last); // RULE1
        rx_smp = sync_mode ? smp_edge : (baud_tick && s.rx_pre == os_mid); // RULE3
        nbits = data_bits({s.csb[CSB_CS2], s.csc[CSC_CS+:2]}); // RULE14 RULE9
        par_en = s.csc[CSC_PM+1];
        par_odd = s.csc[CSC_PM];
        tx_en = s.csb[CSB_TXEN];
        do_wr = s.aw_held & s.w_held;
        wr_ok = do_wr & s.w_en & addr_mapped(s.aw_addr);
        lo_wr = wr_ok && s.aw_addr == OFS_BAUD_LO;
        data_wr = wr_ok && s.aw_addr == OFS_DATA;
        tx_last = (s.tx_state == TX_STOP) && !(s.csc[CSC_SBS] && s.tx_cnt == 4'h0);
        // next frame follows the last stop bit with no gap
        tx_load = tx_bit && s.tx_full && tx_en &&
                  (s.tx_state == TX_IDLE || tx_last); // RULE18 RULE11
        ar_take = arvalid & ~s.rvalid;
        case (araddr)
            OFS_CSA: rd_mux = {s.rx_complete, s.tx_complete, ~s.tx_full, s.frame_error,
                               2'h0, s.double_speed, 1'b0};
            OFS_CSB: rd_mux = {s.csb[7:2], s.rx_data[8], s.csb[CSB_TX8]};
            OFS_CSC: rd_mux = s.csc;
            OFS_BAUD_LO: rd_mux = s.divisor[7:0];
            OFS_BAUD_HI: rd_mux = {4'h0, s.divisor[11:8]};
            OFS_DATA: rd_mux = s.rx_data[7:0];
            default: rd_mux = 8'h00;
        endcase
    end

    always_comb begin
        next_s = s;
        // axi write: address and data taken in either order
        if (awvalid && awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_held = 1'b1;
            next_s.w_data = wdata[7:0];
            next_s.w_en = wstrb[0];
        end
        if (do_wr) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = addr_mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (ar_take) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_mux;
            next_s.rresp = addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        // reading data clears receive flag; a new frame below still wins
        if (ar_take && araddr == OFS_DATA) begin
            next_s.rx_complete = 1'b0;
        end
        if (wr_ok) begin
            case (s.aw_addr)
                OFS_CSA: begin
                    next_s.double_speed = s.w_data[CSA_U2];
                    if (s.w_data[CSA_TXC]) next_s.tx_complete = 1'b0; // RULE26
                end
                OFS_CSB: next_s.csb = s.w_data;
                OFS_CSC: next_s.csc = s.w_data; // RULE13
                OFS_BAUD_LO: next_s.divisor[7:0] = s.w_data;
                OFS_BAUD_HI: next_s.divisor[11:8] = s.w_data[3:0]; // RULE24
                default: ;
            endcase
        end

        // baud generator
        if (baud_tick || lo_wr) begin
            next_s.baud_cnt = next_s.divisor; // RULE23
        end else begin
            next_s.baud_cnt = s.baud_cnt - 12'h001;
        end
        if (sync_mode && master && baud_tick) begin
            next_s.xck_int = ~s.xck_int;
        end
        if (!sync_mode && baud_tick) begin
            next_s.tx_pre = (s.tx_pre == os_last) ? 4'h0 : s.tx_pre + 4'h1;
        end

        // transmitter
        if (tx_load) begin
            next_s.tx_full = 1'b0;
            next_s.tx_shift = s.tx_buf;
            next_s.tx_par = parity_of(s.tx_buf, nbits, par_odd); // RULE16 RULE19
            next_s.tx_state = TX_START;
            next_s.txd = 1'b0; // RULE12
        end else if (tx_bit) begin
            case (s.tx_state)
                TX_IDLE: next_s.txd = 1'b1; // RULE27
                TX_START: begin
                    next_s.tx_state = TX_DATA;
                    next_s.txd = s.tx_shift[0]; // RULE10
                    next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
                    next_s.tx_cnt = 4'h1;
                end
                TX_DATA: begin
                    if (s.tx_cnt == nbits) begin
                        next_s.tx_cnt = 4'h0;
                        next_s.tx_state = par_en ? TX_PARITY : TX_STOP;
                        next_s.txd = par_en ? s.tx_par : 1'b1; // RULE10
                    end else begin
                        next_s.txd = s.tx_shift[0];
                        next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
                        next_s.tx_cnt = s.tx_cnt + 4'h1;
                    end
                end
                TX_PARITY: begin
                    next_s.tx_state = TX_STOP;
                    next_s.txd = 1'b1; // RULE12
                end
                TX_STOP: begin
                    if (!tx_last) begin
                        next_s.tx_cnt = 4'h1;
                    end else begin
                        next_s.tx_state = TX_IDLE;
                        next_s.tx_complete = 1'b1; // RULE26
                    end
                    next_s.txd = 1'b1;
                end
                default: next_s.tx_state = TX_IDLE;
            endcase
        end
        if (data_wr) begin
            next_s.tx_buf = {s.csb[CSB_TX8], s.w_data}; // RULE18
            next_s.tx_full = 1'b1; // RULE25
        end

        // receiver
        if (!sync_mode && baud_tick && s.rx_state != RX_IDLE) begin
            next_s.rx_pre = (s.rx_pre == os_last) ? 4'h0 : s.rx_pre + 4'h1;
        end
        case (s.rx_state)
            RX_IDLE: begin
                next_s.rx_cnt = 4'h0;
                if (s.csb[CSB_RXEN] && !rxd_in) begin
                    if (sync_mode && smp_edge) begin
                        next_s.rx_state = RX_DATA;
                    end else if (!sync_mode && baud_tick) begin
                        next_s.rx_state = RX_START;
                        next_s.rx_pre = 4'h1;
                    end
                end
            end
            RX_START: if (rx_smp) next_s.rx_state = rxd_in ? RX_IDLE : RX_DATA;
            RX_DATA: begin
                if (rx_smp) begin
                    next_s.rx_shift = {rxd_in, s.rx_shift[8:1]};
                    next_s.rx_cnt = s.rx_cnt + 4'h1;
                    if (s.rx_cnt + 4'h1 == nbits) begin
                        next_s.rx_state = par_en ? RX_PARITY : RX_STOP;
                    end
                end
            end
            RX_PARITY: if (rx_smp) next_s.rx_state = RX_STOP;
            RX_STOP: begin
                if (rx_smp) begin
                    // second stop bit is never looked at
                    next_s.frame_error = ~rxd_in; // RULE15
                    next_s.rx_data = s.rx_shift >> (4'h9 - nbits);
                    next_s.rx_complete = 1'b1;
                    next_s.rx_state = RX_IDLE;
                end
            end
            default: next_s.rx_state = RX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.csb <= CSB_RESET;
            s.csc <= CSC_RESET;
            s.divisor <= DIVISOR_RESET;
            s.baud_cnt <= DIVISOR_RESET;
            s.tx_state <= TX_IDLE;
            s.rx_state <= RX_IDLE;
            s.txd <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign awready = ~s.aw_held & ~s.bvalid;
    assign wready = ~s.w_held & ~s.bvalid;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = ~s.rvalid;
    assign rvalid = s.rvalid;
    assign rdata = {24'h000000, s.rdata};
    assign rresp = s.rresp;
    // pin stays ours until the frame in the shifter has gone out
    assign txd_out = s.txd;
    assign txd_oe = tx_en | (s.tx_state != TX_IDLE); // RULE17
    assign xck_out = s.xck_int;
    assign xck_oe = sync_mode & master; // RULE6

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_start_bit_low: assert property (s.tx_state == TX_START |-> !txd_out) // RULE12
        else $error("start bit not low");
    a_stop_bit_high: assert property (s.tx_state == TX_STOP |-> txd_out) // RULE12
        else $error("stop bit not high");
    a_idle_line_high: assert property ((s.tx_state == TX_IDLE && txd_oe) |-> txd_out) // RULE27
        else $error("idle line not high");
    a_buffer_flag_write: assert property (data_wr |=> s.tx_full ##0 !rd_mux[CSA_TBE] // RULE25
        || araddr != OFS_CSA)
        else $error("buffer empty after data write");
    a_tx_complete_set: assert property ($rose(s.tx_complete) |-> // RULE26
        $past(s.tx_state == TX_STOP) && s.tx_state == TX_IDLE)
        else $error("transmit complete without frame end");
    a_baud_reload: assert property ((baud_tick && !lo_wr) |=> // RULE23
        s.baud_cnt == s.divisor)
        else $error("baud counter not reloaded");
    a_master_clock_toggle: assert property ((xck_oe && baud_tick) |=> // RULE6
        xck_out != $past(xck_out))
        else $error("master transfer clock not toggling");
    a_slave_edge_delay: assert property ((sync_mode && !master && chg_edge && // RULE4
        !s.csc[CSC_POL]) |-> $past(xck_in, SYNC_DELAY) && !$past(xck_in, SYNC_DELAY + 1))
        else $error("slave edge not two clocks late");
    a_double_rate: assert property ((!sync_mode && tx_bit) |-> // RULE1
        ##1 (sync_mode || !tx_bit) [*7])
        else $error("bit period shorter than eight ticks");
    a_parity_bit: assert property ((s.tx_state == TX_DATA && tx_bit && s.tx_cnt == nbits && par_en) // RULE16
        |=> s.tx_state == TX_PARITY && txd_out == $past(s.tx_par))
        else $error("parity bit not sent");
endmodule

//--- usart_peer.sv
`timescale 1ns/1ns
module usart_peer (
    // clock
    input wire logic aclk,
    // serial line from the block
    input wire logic txd_out,
    input wire logic txd_oe,
    // lines toward the block
    output logic rxd_in,
    output logic xck_in
);
    // released pin reads the pull-up level
    wire logic line = txd_oe ? txd_out : 1'b1;
    initial begin
        rxd_in = 1'b1;
        xck_in = 1'b0; // slave clock stands still, far below aclk/4
    end
    // samples mid-bit; wait_n tells how long the line stayed high
    task automatic capture(input int per, input int len, output logic [12:0] bits,
                           output int wait_n);
        bits = '0;
        wait_n = 0;
        @(posedge aclk);
        while (line !== 1'b0) begin
            @(posedge aclk);
            wait_n++;
        end
        repeat (per / 2) @(posedge aclk);
        for (int i = 0; i < len; i++) begin
            bits[i] = line;
            if (i < len - 1) repeat (per) @(posedge aclk);
        end
    endtask
    // slave clock runs only for a bounded burst and rests low
    task automatic run_clock(input int half, input int toggles);
        repeat (toggles) begin
            repeat (half) @(posedge aclk);
            xck_in <= ~xck_in;
        end
    endtask
endmodule

//--- test_usart_clock_frame_transmit.sv
`timescale 1ns/1ns
module test_usart_clock_frame_transmit
    import usart_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    logic txd_out, txd_oe, rxd_in, xck_in, xck_out, xck_oe;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #5 aclk = ~aclk;

    usart_core dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .txd_out(txd_out), .txd_oe(txd_oe),
        .rxd_in(rxd_in), .xck_in(xck_in), .xck_out(xck_out), .xck_oe(xck_oe));

    usart_peer peer (.aclk(aclk), .txd_out(txd_out), .txd_oe(txd_oe), .rxd_in(rxd_in),
        .xck_in(xck_in));

    task automatic print_verdict;
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            print_verdict;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // entered just after an edge; each channel released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        r = bresp;
        // one edge between calls so bready is never set twice in one step
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        @(posedge aclk);
    endtask

    function automatic logic [12:0] frame_bits(input logic [8:0] d, input int n,
                                               input logic [1:0] pm, input logic sbs,
                                               output int len);
        logic p;
        p = pm[0];
        len = n + 2 + int'(pm[1]) + int'(sbs);
        frame_bits = 13'h1fff;
        frame_bits[0] = 1'b0;
        for (int i = 0; i < n; i++) begin
            frame_bits[i + 1] = d[i];
            p = p ^ d[i];
        end
        if (pm[1]) frame_bits[n + 1] = p;
        for (int i = len; i < 13; i++) frame_bits[i] = 1'b0;
    endfunction

    task automatic test_reset;
        logic [31:0] v;
        logic [1:0] r;
        check({30'h0, txd_out, txd_oe}, 32'h2);
        rd(OFS_CSA, v, r);
        check(v, 32'h20);
        rd(OFS_CSC, v, r);
        check(v, 32'h06);
        wr(OFS_BAUD_HI, 32'hff, r);
        rd(OFS_BAUD_HI, v, r);
        check(v, 32'h0f);
        wr(OFS_BAUD_HI, 32'h0, r);
        rd(8'h18, v, r);
        check({v[29:0], r}, {30'h0, RESP_SLVERR});
        wr(8'h1c, 32'h1, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
    endtask

    // format written only while the line is idle, tx-complete cleared last before the data write
    task automatic tx_format(input logic [2:0] cs, input logic [1:0] pm, input logic sbs,
                             input logic [8:0] d, input logic u2x, input logic [7:0] div);
        logic [12:0] got, exp;
        logic [31:0] v;
        logic [1:0] r;
        int len, per, n, wn;
        n = (cs == 3'h7) ? 9 : (cs > 3'h3) ? 8 : int'(cs) + 5;
        exp = frame_bits(d, n, pm, sbs, len);
        per = (u2x ? 8 : 16) * (int'(div) + 1);
        wr(OFS_BAUD_LO, {24'h0, div}, r);
        wr(OFS_CSB, {29'h1, cs[2], 1'b0, d[8]}, r);
        wr(OFS_CSC, {26'h0, pm, sbs, cs[1:0], 1'b0}, r);
        wr(OFS_CSA, {24'h0, 6'h10, u2x, 1'b0}, r);
        fork
            peer.capture(per, len, got, wn);
            wr(OFS_DATA, {23'h0, d}, r);
        join
        check({19'h0, got}, {19'h0, exp});
        repeat (per) @(posedge aclk);
        rd(OFS_CSA, v, r);
        check(v, {24'h0, 6'h18, u2x, 1'b0});
        check({31'h0, txd_out}, 32'h1);
    endtask

    task automatic back_to_back;
        logic [12:0] g1, g2, e1, e2;
        logic [31:0] v;
        logic [1:0] r;
        int len, w1, w2;
        v = '0;
        fork
            begin
                peer.capture(16, 10, g1, w1);
                peer.capture(16, 10, g2, w2);
            end
            begin
                wr(OFS_DATA, 32'h3c, r);
                while (v[CSA_TBE] !== 1'b1) begin
                    rd(OFS_CSA, v, r);
                end
                wr(OFS_DATA, 32'hc3, r);
            end
        join
        e1 = frame_bits(9'h03c, 8, 2'b00, 1'b0, len);
        e2 = frame_bits(9'h0c3, 8, 2'b00, 1'b0, len);
        check({19'h0, g1}, {19'h0, e1});
        check({19'h0, g2}, {19'h0, e2});
        // second start must follow the first stop without an idle gap
        check({31'h0, w2 < 10}, 32'h1);
    endtask

    task automatic sync_master;
        logic [12:0] got, exp;
        logic [1:0] r;
        logic x0;
        int len, wn;
        exp = frame_bits(9'h096, 8, 2'b00, 1'b0, len);
        // let the last stop bit finish before touching the format
        repeat (16) @(posedge aclk);
        wr(OFS_CSA, 32'h40, r);
        wr(OFS_CSB, 32'h08, r);
        wr(OFS_CSC, 32'hc6, r);
        check({30'h0, xck_oe, txd_oe}, 32'h3);
        fork
            peer.capture(2, len, got, wn);
            wr(OFS_DATA, 32'h96, r);
        join
        check({19'h0, got}, {19'h0, exp});
        x0 = xck_out;
        @(posedge aclk);
        check({31'h0, xck_out ^ x0}, 32'h1);
        wr(OFS_CSC, 32'h86, r);
        check({31'h0, xck_oe}, 32'h0);
    endtask

    // slave clock period is eight system clocks, inside the quarter-rate limit
    task automatic sync_slave;
        logic [12:0] got, exp;
        logic [1:0] r;
        int len, wn;
        exp = frame_bits(9'h069, 8, 2'b00, 1'b0, len);
        wr(OFS_CSC, 32'h46, r);
        check({31'h0, xck_oe}, 32'h0);
        fork
            peer.run_clock(4, 24);
            peer.capture(8, len, got, wn);
            wr(OFS_DATA, 32'h69, r);
        join
        check({19'h0, got}, {19'h0, exp});
        wr(OFS_CSC, 32'h06, r);
    endtask

    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset;
        tx_format(3'h0, 2'h2, 1'b1, 9'h1ff, 1'b0, 8'h00);
        tx_format(3'h1, 2'h3, 1'b0, 9'h0d2, 1'b1, 8'h00);
        tx_format(3'h2, 2'h2, 1'b0, 9'h0ff, 1'b1, 8'h01);
        tx_format(3'h7, 2'h3, 1'b1, 9'h15a, 1'b0, 8'h00);
        tx_format(3'h3, 2'h0, 1'b0, 9'h0a5, 1'b0, 8'h01);
        tx_format(3'h5, 2'h0, 1'b0, 9'h1c3, 1'b0, 8'h00);
        back_to_back;
        sync_master;
        sync_slave;
        print_verdict;
    end
endmodule
